// file: core/block_output_defs.svh
// How it works
// - ED 8B: memory byte to page-zero port
// - once-decrement: pointer, port, counter minus one
// - single-step flags from new counter and data
// - single-step takes 14 or 15 states
// - ED 9B repeats until counter zero, 256
// - repeat pauses for interrupts, then resumes transparently
// - repeat iterations 16/17, final 14/15 states
// - repeat completion: S,H,C clear; Z,P set
// - ED BB: counter minus one as high byte, port low
// - full repeat decrements pointer, 256 from zero
// - full repeat: interrupts and refresh between transfers
// - ED 83 increments pointer and port
`ifndef BLOCK_OUTPUT_DEFS_SVH
`define BLOCK_OUTPUT_DEFS_SVH

// register byte offsets
`define REG_CTRL            8'h00
`define REG_POINTER         8'h04
`define REG_PORT            8'h08
`define REG_COUNT           8'h0c
`define REG_FLAGS           8'h10
`define REG_STATUS          8'h14
`define REG_LAST            8'h18

// control and status word fields
`define CTRL_PREFIX         15:8
`define CTRL_OPCODE         7:0
`define STATUS_BUSY         0
`define STATUS_PAUSED       1
`define STATUS_BADOP        2

// opcode bytes
`define PREFIX_BYTE         8'hed
`define OP_P0_DEC_ONCE      8'h8b
`define OP_P0_INC_ONCE      8'h83
`define OP_P0_DEC_REPEAT    8'h9b
`define OP_FULL_DEC_REPEAT  8'hbb

// reset values and constants
`define POINTER_RST         16'h0000
`define BYTE_RST            8'h00
`define BYTE_MAX            8'hff
`define PAGE_ZERO           8'h00
`define INTERNAL_PORT_TOP   8'h3f
`define NIBBLE_ZERO         4'h0

// clock states per iteration
`define T_ONCE_INT          5'd14
`define T_ONCE_EXT          5'd15
`define T_REP_INT           5'd16
`define T_REP_EXT           5'd17
`define T_FULL_INT          5'd14
`define T_FULL_EXT          5'd15
`define T_FULL_LAST_INT     5'd12
`define T_FULL_LAST_EXT     5'd13
`define T_STEP              5'd1

// ahb-lite
`define HTRANS_ACTIVE_BIT   1
`define HRESP_OKAY          1'b0

`endif

// file: core/block_output_pkg.sv
package block_output_pkg;

   typedef enum logic [2:0] {
      S_IDLE,
      S_READ,
      S_WRITE,
      S_SEND,
      S_UPDATE,
      S_PAD,
      S_INTWAIT,
      S_REFRESH
   } state_t;

   typedef enum logic [1:0] {
      M_ONCE,
      M_REPEAT,
      M_FULL
   } mode_t;

   typedef struct packed {
      logic sign;
      logic zero;
      logic rsv5;
      logic half;
      logic rsv3;
      logic parity;
      logic subtract;
      logic carry;
   } flags_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] offset;
   } busPhase_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  data;
   } ioWord_t;

endpackage

// file: core/block_output_sequencer.sv
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "block_output_defs.svh"
module block_output_sequencer (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // memory read port
   output logic             memReq,
   output logic [15:0]      memAddr,
   input  wire logic        memValid,
   input  wire logic [7:0]  memData,
   // i/o write port
   output logic             ioValid,
   output logic [15:0]      ioAddr,
   output logic [7:0]       ioData,
   input  wire logic        ioReady,
   // interrupt and refresh
   input  wire logic        irqReq,
   output logic             irqAck,
   output logic             refresh
);
   block_output_pkg::state_t    state_r;
   block_output_pkg::state_t    stateNxt;
   block_output_pkg::mode_t     mode_r;
   block_output_pkg::flags_t    flags_r;
   block_output_pkg::busPhase_t phase_r;
   block_output_pkg::ioWord_t   io_r;

   logic [15:0] pointer_r;
   logic [7:0]  port_r;
   logic [7:0]  count_r;
   logic [7:0]  last_r;
   logic        incr_r;
   logic        extPort_r;
   logic        badOp_r;
   logic [4:0]  tCnt_r;
   logic        irqMeta_r;
   logic        irqSync_r;
   logic        memReq_r;
   logic        ioValid_r;
   logic        irqAck_r;
   logic        refresh_r;
   logic [31:0] hrdata_r;
   logic        hreadyout_r;
   logic        bufInReady;
   logic        bufOutValid;
   logic [7:0]  bufOutData;

   // bus decode
   wire        addrPhase = hsel && htrans[`HTRANS_ACTIVE_BIT] && hready;
   wire        dataWrite = phase_r.valid && phase_r.write;
   wire        dataRead  = phase_r.valid && !phase_r.write;
   wire        idle      = (state_r == block_output_pkg::S_IDLE);
   wire        wrCtrl    = dataWrite && (phase_r.offset == `REG_CTRL);
   wire        wrPointer = dataWrite && (phase_r.offset == `REG_POINTER) && idle;
   wire        wrPort    = dataWrite && (phase_r.offset == `REG_PORT) && idle;
   wire        wrCount   = dataWrite && (phase_r.offset == `REG_COUNT) && idle;
   wire        wrFlags   = dataWrite && (phase_r.offset == `REG_FLAGS) && idle;
   wire        wrStatus  = dataWrite && (phase_r.offset == `REG_STATUS);

   // opcode decode
   wire [7:0]  opByte    = hwdata[`CTRL_OPCODE];
   wire        prefixOk  = (hwdata[`CTRL_PREFIX] == `PREFIX_BYTE);
   wire        opDecOnce = prefixOk && (opByte == `OP_P0_DEC_ONCE);
   wire        opIncOnce = prefixOk && (opByte == `OP_P0_INC_ONCE);
   wire        opDecRep  = prefixOk && (opByte == `OP_P0_DEC_REPEAT);
   wire        opFullRep = prefixOk && (opByte == `OP_FULL_DEC_REPEAT);
   wire        opKnown   = opDecOnce || opIncOnce || opDecRep || opFullRep;
   wire        start     = wrCtrl && idle && opKnown;
   wire        badOpSet  = wrCtrl && idle && !opKnown;

   block_output_pkg::mode_t startMode;
   assign startMode = opDecRep  ? block_output_pkg::M_REPEAT :
                      opFullRep ? block_output_pkg::M_FULL :
                                  block_output_pkg::M_ONCE;

   // register read mux
   wire [31:0] statusWord = {29'h0000000, badOp_r,
                             (state_r == block_output_pkg::S_INTWAIT), !idle};
   wire [7:0]  rdOff      = phase_r.offset;
   wire [31:0] readMux    =
      (rdOff == `REG_POINTER) ? {16'h0000, pointer_r} :
      (rdOff == `REG_PORT)    ? {24'h000000, port_r} :
      (rdOff == `REG_COUNT)   ? {24'h000000, count_r} :
      (rdOff == `REG_FLAGS)   ? {24'h000000, flags_r & 8'hd7} :
      (rdOff == `REG_STATUS)  ? statusWord :
      (rdOff == `REG_LAST)    ? {24'h000000, last_r} :
                                32'h00000000;

   // datapath arithmetic, wrapping by width
   wire [7:0]  countDec  = count_r - 8'h01;
   wire [7:0]  portStep  = incr_r ? port_r + 8'h01 : port_r - 8'h01;
   wire [15:0] ptrStep   = incr_r ? pointer_r + 16'h0001
                                  : pointer_r - 16'h0001;
   wire        fullMode  = (mode_r == block_output_pkg::M_FULL);
   wire [7:0]  upperAddr = fullMode ? countDec : `PAGE_ZERO;
   wire        extNxt    = fullMode || (port_r > `INTERNAL_PORT_TOP);
   wire        finished  = (mode_r == block_output_pkg::M_ONCE) || (count_r == `BYTE_RST);

   // clock states for the iteration just ending
   wire [4:0]  tTarget   =
      (mode_r == block_output_pkg::M_ONCE) ?
         (extPort_r ? `T_ONCE_EXT : `T_ONCE_INT) :
      (mode_r == block_output_pkg::M_REPEAT) ?
         (finished ? (extPort_r ? `T_ONCE_EXT : `T_ONCE_INT)
                   : (extPort_r ? `T_REP_EXT : `T_REP_INT)) :
         (finished ? (extPort_r ? `T_FULL_LAST_EXT : `T_FULL_LAST_INT)
                   : (extPort_r ? `T_FULL_EXT : `T_FULL_INT));
   // a following refresh cycle counts inside the iteration's states
   wire [4:0]  padLast   = (fullMode && !finished) ? tTarget - `T_STEP - `T_STEP
                                                   : tTarget - `T_STEP;
   wire        padDone   = (tCnt_r >= padLast);
   wire        pushByte  = (state_r == block_output_pkg::S_READ) && memValid;
   wire        popByte   = (state_r == block_output_pkg::S_WRITE) && bufOutValid;
   wire        afterPause = fullMode ? 1'b1 : 1'b0;

   // sequencing
   always_comb begin
      stateNxt = state_r;
      case (state_r)
         block_output_pkg::S_IDLE: begin
            if (start) stateNxt = block_output_pkg::S_READ;
         end
         block_output_pkg::S_READ: begin
            if (pushByte && bufInReady) stateNxt = block_output_pkg::S_WRITE;
         end
         block_output_pkg::S_WRITE: begin
            if (popByte) stateNxt = block_output_pkg::S_SEND;
         end
         block_output_pkg::S_SEND: begin
            if (ioReady) stateNxt = block_output_pkg::S_UPDATE;
         end
         block_output_pkg::S_UPDATE: begin
            stateNxt = block_output_pkg::S_PAD;
         end
         block_output_pkg::S_PAD: begin
            if (padDone) begin
               if (finished) stateNxt = block_output_pkg::S_IDLE;
               else if (irqSync_r) stateNxt = block_output_pkg::S_INTWAIT;
               else if (fullMode) stateNxt = block_output_pkg::S_REFRESH;
               else stateNxt = block_output_pkg::S_READ;
            end
         end
         block_output_pkg::S_INTWAIT: begin
            if (!irqSync_r) begin
               stateNxt = afterPause ? block_output_pkg::S_REFRESH
                                     : block_output_pkg::S_READ;
            end
         end
         block_output_pkg::S_REFRESH: begin
            stateNxt = block_output_pkg::S_READ;
         end
         default: stateNxt = block_output_pkg::S_IDLE;
      endcase
   end

   // interrupt request synchroniser
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irqMeta_r <= 1'b0;
         irqSync_r <= 1'b0;
      end else begin
         irqMeta_r <= irqReq;
         irqSync_r <= irqMeta_r;
      end
   end

   // bus phases
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         phase_r     <= '0;
         hrdata_r    <= 32'h00000000;
         hreadyout_r <= 1'b1;
      end else begin
         if (hreadyout_r) begin
            phase_r.valid  <= addrPhase;
            phase_r.write  <= hwrite;
            phase_r.offset <= haddr[7:0];
            hreadyout_r    <= !(addrPhase && !hwrite);
         end else begin
            phase_r.valid  <= 1'b0;
            hreadyout_r    <= 1'b1;
         end
         if (dataRead) hrdata_r <= readMux;
      end
   end

   // state and timing
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_r <= block_output_pkg::S_IDLE;
         tCnt_r  <= 5'd0;
      end else begin
         state_r <= stateNxt;
         if (stateNxt == block_output_pkg::S_READ && state_r != block_output_pkg::S_READ)
            tCnt_r <= 5'd0;
         else if (tCnt_r != 5'h1f)
            tCnt_r <= tCnt_r + `T_STEP;
      end
   end

   // output strobes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         memReq_r  <= 1'b0;
         irqAck_r  <= 1'b0;
         refresh_r <= 1'b0;
      end else begin
         memReq_r  <= (stateNxt == block_output_pkg::S_READ);
         irqAck_r  <= (stateNxt == block_output_pkg::S_INTWAIT);
         refresh_r <= (stateNxt == block_output_pkg::S_REFRESH);
      end
   end

   // i/o write word
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         io_r      <= '0;
         ioValid_r <= 1'b0;
         extPort_r <= 1'b0;
      end else if (popByte) begin
         io_r.addr <= {upperAddr, port_r};
         io_r.data <= bufOutData;
         ioValid_r <= 1'b1;
         extPort_r <= extNxt;
      end else if (state_r == block_output_pkg::S_SEND && ioReady) begin
         ioValid_r <= 1'b0;
      end
   end

   // programmer-visible registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pointer_r <= `POINTER_RST;
         port_r    <= `BYTE_RST;
         count_r   <= `BYTE_RST;
         last_r    <= `BYTE_RST;
         flags_r   <= '0;
         mode_r    <= block_output_pkg::M_ONCE;
         incr_r    <= 1'b0;
         badOp_r   <= 1'b0;
      end else begin
         if (wrPointer) pointer_r <= hwdata[15:0];
         if (wrPort) port_r <= hwdata[7:0];
         if (wrCount) count_r <= hwdata[7:0];
         if (wrFlags) flags_r <= hwdata[7:0] & 8'hd7;
         if (badOpSet) badOp_r <= 1'b1;
         else if (wrStatus && hwdata[`STATUS_BADOP]) badOp_r <= 1'b0;
         if (start) begin
            mode_r <= startMode;
            incr_r <= opIncOnce;
         end
         if (state_r == block_output_pkg::S_UPDATE) begin
            last_r    <= io_r.data;
            pointer_r <= ptrStep;
            count_r   <= countDec;
            if (!fullMode) port_r <= portStep;
            case (mode_r)
               block_output_pkg::M_ONCE: begin
                  flags_r.sign     <= countDec[7];
                  flags_r.zero     <= (countDec == `BYTE_RST);
                  flags_r.half     <= (count_r[3:0] == `NIBBLE_ZERO);
                  flags_r.parity   <= ~^countDec;
                  flags_r.subtract <= io_r.data[7];
                  flags_r.carry    <= (countDec == `BYTE_MAX);
               end
               block_output_pkg::M_REPEAT: begin
                  if (countDec == `BYTE_RST) begin
                     flags_r.sign     <= 1'b0;
                     flags_r.zero     <= 1'b1;
                     flags_r.half     <= 1'b0;
                     flags_r.parity   <= 1'b1;
                     flags_r.subtract <= io_r.data[7];
                     flags_r.carry    <= 1'b0;
                  end
               end
               default: begin
                  if (countDec == `BYTE_RST) begin
                     flags_r.zero     <= 1'b1;
                     flags_r.subtract <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // byte path from memory to the i/o port
   two_entry_buffer #(
      .WIDTH (8),
      .DEPTH (2)
   ) u_buffer (
      .clock    (clock),
      .rst_n    (rst_n),
      .inValid  (pushByte),
      .inReady  (bufInReady),
      .inData   (memData),
      .outValid (bufOutValid),
      .outReady (state_r == block_output_pkg::S_WRITE),
      .outData  (bufOutData)
   );

   assign hrdata    = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp     = `HRESP_OKAY;
   assign memReq    = memReq_r;
   assign memAddr   = pointer_r;
   assign ioValid   = ioValid_r;
   assign ioAddr    = io_r.addr;
   assign ioData    = io_r.data;
   assign irqAck    = irqAck_r;
   assign refresh   = refresh_r;

   wire unusedBits = ^{haddr[31:8], hsize, hwdata[31:16]};
endmodule // block_output_sequencer

// file: core/two_entry_buffer.sv
`timescale 1ns/1ps
module two_entry_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] store_r [DEPTH];
   logic [PW-1:0]    wrPtr_r;
   logic [PW-1:0]    rdPtr_r;
   logic [PW:0]      fill_r;

   wire push = inValid && inReady;
   wire pop  = outValid && outReady;
   wire [PW-1:0] wrPtrNxt = (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
   wire [PW-1:0] rdPtrNxt = (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;

   assign inReady  = (fill_r != (PW+1)'(DEPTH));
   assign outValid = (fill_r != '0);
   assign outData  = store_r[rdPtr_r];

   always_ff @(posedge clock) begin
      if (push) begin
         store_r[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         fill_r  <= '0;
      end else begin
         if (push) wrPtr_r <= wrPtrNxt;
         if (pop) rdPtr_r <= rdPtrNxt;
         if (push && !pop) fill_r <= fill_r + 1'b1;
         else if (pop && !push) fill_r <= fill_r - 1'b1;
      end
   end
endmodule // two_entry_buffer

// file: tb/block_output_sequencer_asserts.sv
`timescale 1ns/1ps
`include "block_output_defs.svh"
module block_output_sequencer_asserts (
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   // memory and i/o
   input wire logic        memReq,
   input wire logic [15:0] memAddr,
   input wire logic        memValid,
   input wire logic [7:0]  memData,
   input wire logic        ioValid,
   input wire logic [15:0] ioAddr,
   input wire logic [7:0]  ioData,
   input wire logic        ioReady,
   // pause and refresh
   input wire logic        irqAck,
   input wire logic        refresh
);
   logic        ctrlWr_r;
   logic [7:0]  op_r;
   logic [7:0]  byte_r;
   logic [15:0] mem_r;
   logic [15:0] io_r;
   logic        seenMem_r;
   logic        seenIo_r;
   wire         page0 = op_r != 8'hbb;
   wire         ioDone = ioValid && ioReady;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   // remember the opcode and the previous transfer of the running operation
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrlWr_r <= 1'b0;
         op_r <= 8'h00;
         byte_r <= 8'h00;
         mem_r <= 16'h0000;
         io_r <= 16'h0000;
         seenMem_r <= 1'b0;
         seenIo_r <= 1'b0;
      end else begin
         ctrlWr_r <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == `REG_CTRL;
         if (ctrlWr_r && !memReq && !ioValid && !irqAck) begin
            op_r <= hwdata[7:0];
            seenMem_r <= 1'b0;
            seenIo_r <= 1'b0;
         end
         if (memReq && memValid) begin
            byte_r <= memData;
            mem_r <= memAddr;
            seenMem_r <= 1'b1;
         end
         if (ioDone) begin
            io_r <= ioAddr;
            seenIo_r <= 1'b1;
         end
      end
   end

   a_page0_upper: assert property (ioValid && page0 |-> ioAddr[15:8] == 8'h00)
      else $error("page-zero write with nonzero upper byte");
   a_mem_held: assert property (memReq && !memValid |=> memReq && $stable(memAddr))
      else $error("memory request dropped or moved");
   a_io_held: assert property (ioValid && !ioReady |=>
      ioValid && $stable({ioAddr, ioData}))
      else $error("io write dropped or changed");
   a_byte_fwd: assert property (memReq && memValid |=>
      !ioValid ##1 ioValid && ioData == byte_r)
      else $error("io byte differs from memory byte");
   a_ptr_dec: assert property ($rose(memReq) && seenMem_r |->
      memAddr == mem_r - 16'h1)
      else $error("pointer not decremented");
   a_port_dec: assert property ($rose(ioValid) && seenIo_r && page0 |->
      ioAddr[7:0] == io_r[7:0] - 8'h1)
      else $error("page-zero port not decremented");
   a_full_addr: assert property ($rose(ioValid) && seenIo_r && !page0 |->
      ioAddr == {io_r[15:8] - 8'h1, io_r[7:0]})
      else $error("full address sequence wrong");
   a_full_more: assert property (ioDone && !page0 && ioAddr[15:8] != 8'h00 |->
      ##[1:100] memReq)
      else $error("full repeat stopped early");
   a_full_last: assert property (ioDone && !page0 && ioAddr[15:8] == 8'h00 |=>
      !memReq [*8])
      else $error("full repeat ran past zero");
   a_refresh_gap: assert property (refresh |-> !page0 && !memReq && !ioValid)
      else $error("refresh outside full repeat gap");
   a_pause_quiet: assert property (irqAck |->
      (op_r == 8'h9b || !page0) && !memReq && !ioValid)
      else $error("pause outside repeat gap");

   cover property (irqAck);
   cover property (refresh);
   cover property (ioDone && op_r == 8'h83);
endmodule // block_output_sequencer_asserts

// file: tb/mem_io_partner.sv
`timescale 1ns/1ps
module mem_io_partner (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // memory side
   input  wire logic        memReq,
   input  wire logic [15:0] memAddr,
   output logic             memValid,
   output logic [7:0]       memData,
   // i/o side
   output logic             ioReady,
   // pace
   input  wire logic        slow
);
   logic [2:0] tick_r;
   wire  [7:0] stored = memAddr[7:0] ^ memAddr[15:8] ^ 8'h3c;
   always_ff @(posedge clock) tick_r <= rst_n ? tick_r + 3'h1 : 3'h0;
   // slow pace answers one cycle in four and refuses half the time
   assign memValid = memReq && (!slow || tick_r[1:0] == 2'h0);
   // data lines carry a changing pattern outside a valid cycle
   assign memData = memValid ? stored : {5'h15, tick_r};
   assign ioReady = !slow || tick_r[2];
endmodule // mem_io_partner

// file: tb/tb_block_output_sequencer.sv
`timescale 1ns/1ps
`include "block_output_defs.svh"
module tb_block_output_sequencer;
   logic        clock, rst_n, hwrite, irqReq, slow, memReqD;
   logic [31:0] haddr, hwdata, r;
   logic [1:0]  htrans;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, memReq, memValid, ioValid, ioReady, irqAck, refresh;
   wire  [15:0] memAddr, ioAddr;
   wire  [7:0]  memData, ioData;
   logic [31:0] got[$];
   int          rise[$];
   int          cyc, acks, refs, irqAt, mismatches, testsRun, seed, k;

   block_output_sequencer dut (.clock(clock), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .memReq(memReq),
      .memAddr(memAddr), .memValid(memValid), .memData(memData), .ioValid(ioValid),
      .ioAddr(ioAddr), .ioData(ioData), .ioReady(ioReady), .irqReq(irqReq),
      .irqAck(irqAck), .refresh(refresh));
   mem_io_partner peer (.clock(clock), .rst_n(rst_n), .memReq(memReq), .memAddr(memAddr),
      .memValid(memValid), .memData(memData), .ioReady(ioReady), .slow(slow));

   function automatic logic [7:0] mem(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction

   task chk(input bit ok, input string m);
      testsRun++;
      if (!ok) begin
         mismatches++;
         $display("ERROR at %0t: %s", $time, m);
      end
   endtask

   task wrap_up;
      $display("checks %0d, mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      q = hrdata;
      chk(hresp === 1'b0, "bus response not okay");
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask

   task run(input logic [7:0] op, input logic [15:0] p, input logic [7:0] pt,
            input logic [7:0] c, input logic s, input int ia);
      logic [7:0] d, f0, fe, nb;
      int         n, i, st;
      got.delete();
      rise.delete();
      acks = 0;
      refs = 0;
      irqAt = ia;
      slow <= s;
      f0 = 8'($urandom) & 8'hd7;
      wr(`REG_POINTER, {16'h0, p});
      wr(`REG_PORT, {24'h0, pt});
      wr(`REG_COUNT, {24'h0, c});
      wr(`REG_FLAGS, {24'h0, f0});
      wr(`REG_CTRL, {16'h0, 8'hed, op});
      i = 0;
      do begin rd(`REG_STATUS, r); i++; end while (r[0] !== 1'b0 && i < 3000);
      n = (op == 8'h8b || op == 8'h83) ? 1 : (c == 8'h00 ? 256 : int'(c));
      st = (op == 8'h83) ? 1 : -1;
      chk(got.size() == n, "transfer count");
      d = 8'h00;
      for (i = 0; i < n && i < got.size(); i++) begin
         d = mem(16'(p + st * i));
         chk(got[i] === {(op == 8'hbb) ? 8'(c - 1 - i) : 8'h00,
            (op == 8'hbb) ? pt : 8'(pt + st * i), d}, "io write");
      end
      if (!s && ia > n)
         for (i = 0; i + 1 < rise.size(); i++)
            chk(rise[i + 1] - rise[i] == ((op == 8'hbb) ? 15 :
               (8'(pt - i) > 8'h3f ? 17 : 16)), "iteration length");
      nb = c - 8'h01;
      fe = (op == 8'h9b) ? {6'b010001, d[7], 1'b0} : (op == 8'hbb) ? (f0 | 8'h42) :
         {nb[7], nb == 8'h00, 1'b0, c[3:0] == 4'h0, 1'b0, ~^nb, d[7], c == 8'h00};
      rd(`REG_FLAGS, r);
      chk(r[7:0] === fe, "flags");
      rd(`REG_POINTER, r);
      chk(r[15:0] === 16'(p + st * n), "pointer");
      rd(`REG_PORT, r);
      chk(r[7:0] === ((op == 8'hbb) ? pt : 8'(pt + st * n)), "port");
      rd(`REG_COUNT, r);
      chk(r[7:0] === 8'(c - n), "count");
      rd(`REG_LAST, r);
      chk(r[7:0] === d, "last byte");
      if (ia < n)
         chk(acks > 0, "no pause");
      if (op == 8'hbb)
         chk(refs == n - 1, "refresh count");
      irqReq <= 1'b0;
   endtask

   // collects io writes, read starts and pauses; raises the interrupt on cue
   always @(posedge clock) begin
      cyc++;
      if (irqAck === 1'b1)
         acks++;
      if (acks > 20)
         irqReq <= 1'b0;
      if (ioValid === 1'b1 && ioReady === 1'b1) begin
         if (got.size() == irqAt)
            irqReq <= 1'b1;
         got.push_back({ioAddr, ioData});
      end
      if (memReq === 1'b1 && memReqD !== 1'b1)
         rise.push_back(cyc);
      if (refresh === 1'b1)
         refs++;
      memReqD = memReq;
   end

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      repeat (60000) @(posedge clock);
      mismatches++;
      $display("ERROR at %0t: run timed out", $time);
      wrap_up;
   end

   initial begin
      rst_n = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      irqReq = 1'b0;
      slow = 1'b0;
      irqAt = 999;
      seed = $urandom(32'h5cca99e9);
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      rd(8'h1c, r);
      chk(r === 32'h0, "unmapped read");
      rd(`REG_STATUS, r);
      chk(r === 32'h0, "status after reset");
      wr(`REG_CTRL, 32'h0000ed44);
      rd(`REG_STATUS, r);
      chk(r[2:0] === 3'b100, "bad opcode flag");
      wr(`REG_STATUS, 32'h4);
      rd(`REG_STATUS, r);
      chk(r === 32'h0, "bad opcode clear");
      run(8'h8b, 16'h4200, 8'h80, 8'h10, 1'b0, 999);
      run(8'h83, 16'hffff, 8'hff, 8'h00, 1'b1, 999);
      run(8'h8b, 16'h0000, 8'h01, 8'h01, 1'b0, 999);
      for (k = 0; k < 3; k++)
         run(k[0] ? 8'h83 : 8'h8b, 16'($urandom), 8'($urandom), 8'($urandom), 1'($urandom), 999);
      run(8'h9b, 16'h4200, 8'h41, 8'h04, 1'b0, 999);
      run(8'h9b, 16'($urandom), 8'($urandom), 8'h00, 1'b1, 999);
      run(8'h9b, 16'h1234, 8'h20, 8'h05, 1'b0, 2);
      run(8'hbb, 16'h1000, 8'h07, 8'h03, 1'b0, 999);
      run(8'hbb, 16'($urandom), 8'($urandom), 8'h00, 1'b0, 999);
      run(8'hbb, 16'h0001, 8'hc0, 8'h04, 1'b1, 1);
      wrap_up;
   end
endmodule // tb_block_output_sequencer

bind block_output_sequencer block_output_sequencer_asserts checker_i (.clock, .rst_n,
   .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .memReq, .memAddr, .memValid,
   .memData, .ioValid, .ioAddr, .ioData, .ioReady, .irqAck, .refresh);
